// ---- hw/adc_consts.svh ----
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH
`define OFF_CTRL      8'h00
`define OFF_RANGE     8'h04
`define OFF_PRESC     8'h08
`define OFF_SAMPLE    8'h0c
`define OFF_DATA      8'h10
`define OFF_PINSEL    8'h14
`define OFF_IRQ_STAT  8'h18
`define OFF_IRQ_MASK  8'h1c
`define OFF_IRQ_PRIO  8'h20
`define OFF_IRQ_ROUTE 8'h24
`define OFF_VEC_BASE  8'h28
`define BIT_EN        0
`define BIT_RUN       1
`define BIT_OWE       2
`define BIT_MODE      3
`define LSB_TRIG      4
`define LSB_CH_END    4
`define BIT_PIN_VALUE 8
`define LSB_DATA_CH   12
`define RST_SAMPLE    8'h09
`define RST_DIV       3'h0
`define RST_PRIO      3'h0
`define RST_VEC_BASE  32'h0000_0000
`define VEC_OFFSET    32'h0000_0100
`define SAR_TOP_BIT   4'h9
`define SAR_MID       10'h200
`endif

// ---- hw/adc_pkg.sv ----
`default_nettype none
package adc_pkg;
   typedef enum logic [1:0] {
      TRIG_EXT   = 2'b00,
      TRIG_TMR8  = 2'b01,
      TRIG_TMR16 = 2'b10,
      TRIG_SOFT  = 2'b11
   } trig_type;
   typedef enum logic {SEQ_IDLE = 1'b0, SEQ_BUSY = 1'b1} seq_type;
   typedef enum logic [1:0] {
      SAR_IDLE    = 2'b00,
      SAR_SAMPLE  = 2'b01,
      SAR_CONVERT = 2'b10
   } sar_state_type;
   typedef struct packed {
      logic       start;
      logic [2:0] ch;
      logic [7:0] samp;
   } sar_req_type;
   typedef struct packed {
      logic       done;
      logic [2:0] ch;
      logic [9:0] value;
   } sar_res_type;
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } presc_state_type;
   typedef struct packed {
      sar_state_type st;
      logic [7:0]    cnt;
      logic [3:0]    bitpos;
      logic [9:0]    acc;
      logic          sample;
      sar_res_type   res;
   } sar_reg_type;
   typedef struct packed {
      logic en, run, overwrite_error_flag, cont;
      trig_type trig;
      logic [2:0] ch_start, ch_end, div_sel, cur_ch, res_ch, prio, trig_prev;
      logic [7:0] samp, addr;
      logic [9:0] result;
      logic unread, ana_sel, route, start, wr_pend, rd_pend, ready, resp, irq, dma_req;
      logic [1:0] factor, enable;
      logic [31:0] vec_base, vec_out, rdata;
      seq_type seq;
   } top_state_type;
endpackage
`default_nettype wire

// ---- hw/adc_prescaler.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.svh"
module adc_prescaler
   import adc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [2:0] sel,
   output logic            tick
);
   presc_state_type s, n;
   logic [8:0]      last;

   // Ratio 2^(sel+1): sel 0 gives /2, sel 7 gives /256
   assign last = 9'(9'h002 << sel) - 9'h001;

   always_comb begin
      n = s;
      n.tick = 1'b0;
      if (!run) begin
         n.cnt = 8'h00;
      end else if (s.cnt == last[7:0]) begin
         n.cnt = 8'h00;
         n.tick = 1'b1;
      end else begin
         n.cnt = s.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) s <= '0;
      else s <= n;
   end
   assign tick = s.tick;

   chk_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
      s.tick |=> !s.tick) else $error("prescaler ticks back to back");
endmodule // adc_prescaler
`default_nettype wire

// ---- hw/adc_sar_engine.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.svh"
module adc_sar_engine
   import adc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        tick,
   input  wire sar_req_type req,
   input  wire logic        cmp,
   output sar_res_type      res,
   output logic             sample,
   output logic [9:0]       dac
);
   sar_reg_type s, n;

   always_comb begin
      n = s;
      n.res.done = 1'b0;
      unique case (s.st)
         SAR_IDLE: if (req.start) begin
            n.st = SAR_SAMPLE;
            n.cnt = (req.samp == 8'h00) ? 8'h01 : req.samp;
            n.res.ch = req.ch;
            n.sample = 1'b1;
         end
         SAR_SAMPLE: if (tick) begin
            if (s.cnt == 8'h01) begin
               n.sample = 1'b0;
               n.st = SAR_CONVERT;
               n.bitpos = `SAR_TOP_BIT;
               n.acc = `SAR_MID;
            end else n.cnt = s.cnt - 8'h01;
         end
         SAR_CONVERT: if (tick) begin
            n.acc[s.bitpos] = cmp;
            if (s.bitpos == 4'h0) begin
               n.st = SAR_IDLE;
               n.res.done = 1'b1;
               n.res.value = n.acc;
            end else begin
               n.bitpos = s.bitpos - 4'h1;
               n.acc[s.bitpos - 4'h1] = 1'b1;
            end
         end
         default: n.st = SAR_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) s <= '0;
      else s <= n;
   end
   assign res = s.res;
   assign sample = s.sample;
   assign dac = s.acc;

   chk_last_bit_done: assert property (@(posedge clk) disable iff (!rst_n)
      s.st == SAR_CONVERT && tick && s.bitpos == 4'h0 |=> s.res.done && s.st == SAR_IDLE)
      else $error("conversion did not finish after lowest bit");
endmodule // adc_sar_engine
`default_nettype wire

// ---- hw/adc_sequencer_control.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.svh"
module adc_sequencer_control
   import adc_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic             HREADYOUT,
   output logic [31:0]      HRDATA,
   output logic             HRESP,
   input  wire logic        SHARED_PIN_IN,
   output logic             ANA_CH0_EN,
   output logic [2:0]       ANA_CH_SEL,
   output logic             ANA_SAMPLE,
   output logic [9:0]       ANA_DAC,
   input  wire logic        ANA_CMP,
   input  wire logic        EXT_TRIG,
   input  wire logic        TMR8_TRIG,
   input  wire logic        TMR16_TRIG,
   output logic             IRQ,
   output logic [2:0]       IRQ_LEVEL,
   output logic [31:0]      IRQ_VECTOR,
   output logic             DMA_REQ
);
   top_state_type s, n;
   sar_req_type   req;
   sar_res_type   res;
   logic          tick;
   logic [2:0]    trig_now;
   logic          trig_edge;
   logic          data_read;

   ////////////////////////////////////////////////////////////////////////
   assign trig_now = {TMR16_TRIG, TMR8_TRIG, EXT_TRIG};
   // Hardware sources start on a rising edge only
   assign trig_edge = (s.trig != TRIG_SOFT) && trig_now[s.trig] && !s.trig_prev[s.trig];
   assign data_read = s.rd_pend && (s.addr == `OFF_DATA);

   assign req.start = s.start;
   assign req.ch = s.cur_ch;
   assign req.samp = s.samp;

   adc_prescaler u_presc (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .run   (s.en),
      .sel   (s.div_sel),
      .tick  (tick)
   );

   adc_sar_engine u_sar (
      .clk    (SYS_CLK),
      .rst_n  (RST_N),
      .tick   (tick),
      .req    (req),
      .cmp    (ANA_CMP),
      .res    (res),
      .sample (ANA_SAMPLE),
      .dac    (ANA_DAC)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = s;
      n.start = 1'b0;
      n.dma_req = 1'b0;
      n.wr_pend = 1'b0;
      n.resp = 1'b0;
      n.trig_prev = trig_now;

      // Address phase; reads take one wait state so data is registered
      if (HSEL && HREADY && HTRANS[1]) begin
         n.addr = HADDR[7:0];
         n.wr_pend = HWRITE;
         n.rd_pend = !HWRITE;
         n.ready = HWRITE;
      end

      if (s.rd_pend) begin
         n.rd_pend = 1'b0;
         n.ready = 1'b1;
         n.rdata = 32'h0000_0000;
         case (s.addr)
            `OFF_CTRL: begin
               n.rdata[`BIT_EN] = s.en;
               n.rdata[`BIT_RUN] = s.run;
               n.rdata[`BIT_OWE] = s.overwrite_error_flag;
               n.rdata[`BIT_MODE] = s.cont;
               n.rdata[`LSB_TRIG +: 2] = s.trig;
            end
            `OFF_RANGE: begin
               n.rdata[2:0] = s.ch_start;
               n.rdata[`LSB_CH_END +: 3] = s.ch_end;
            end
            `OFF_PRESC: n.rdata[2:0] = s.div_sel;
            `OFF_SAMPLE: n.rdata[7:0] = s.samp;
            `OFF_DATA: begin
               n.rdata[9:0] = s.result;
               n.rdata[`LSB_DATA_CH +: 3] = s.res_ch;
               n.unread = 1'b0;
            end
            `OFF_PINSEL: begin
               n.rdata[0] = s.ana_sel;
               // Digital value reads zero once the pin is analog
               n.rdata[`BIT_PIN_VALUE] = SHARED_PIN_IN && !s.ana_sel;
            end
            `OFF_IRQ_STAT: n.rdata[1:0] = s.factor;
            `OFF_IRQ_MASK: n.rdata[1:0] = s.enable;
            `OFF_IRQ_PRIO: n.rdata[2:0] = s.prio;
            `OFF_IRQ_ROUTE: n.rdata[0] = s.route;
            `OFF_VEC_BASE: n.rdata = s.vec_base;
            default: n.rdata = 32'h0000_0000;
         endcase
      end

      // Data phase of a write
      if (s.wr_pend) begin
         case (s.addr)
            `OFF_CTRL: begin
               n.en = HWDATA[`BIT_EN];
               n.run = HWDATA[`BIT_RUN];
               n.cont = HWDATA[`BIT_MODE];
               n.trig = trig_type'(HWDATA[`LSB_TRIG +: 2]);
               // Writing zero clears the error; read-modify-write keeps it
               if (!HWDATA[`BIT_OWE]) n.overwrite_error_flag = 1'b0;
            end
            `OFF_RANGE: begin
               n.ch_start = HWDATA[2:0];
               n.ch_end = HWDATA[`LSB_CH_END +: 3];
            end
            `OFF_PRESC: n.div_sel = HWDATA[2:0];
            `OFF_SAMPLE: n.samp = HWDATA[7:0];
            `OFF_PINSEL: n.ana_sel = HWDATA[0];
            `OFF_IRQ_STAT: n.factor = s.factor & ~HWDATA[1:0];
            `OFF_IRQ_MASK: n.enable = HWDATA[1:0];
            `OFF_IRQ_PRIO: n.prio = HWDATA[2:0];
            `OFF_IRQ_ROUTE: n.route = HWDATA[0];
            `OFF_VEC_BASE: n.vec_base = HWDATA;
            default: n.addr = s.addr;
         endcase
      end

      // Sequencer; its flag sets come last so they win over clears
      unique case (s.seq)
         SEQ_IDLE: begin
            if (s.en && s.run && (s.trig == TRIG_SOFT || trig_edge)) begin
               n.cur_ch = s.ch_start;
               n.start = 1'b1;
               n.seq = SEQ_BUSY;
            end
         end
         SEQ_BUSY: begin
            if (!s.en) begin
               n.seq = SEQ_IDLE;
            end else if (res.done) begin
               n.result = res.value;
               n.res_ch = res.ch;
               n.unread = 1'b1;
               n.factor[0] = 1'b1;
               // A read in this very cycle took the old result
               if (s.unread && !data_read) begin
                  n.overwrite_error_flag = 1'b1;
                  n.factor[1] = 1'b1;
               end
               n.dma_req = s.route;
               if (s.cur_ch != s.ch_end) begin
                  n.cur_ch = s.cur_ch + 3'h1;
                  n.start = 1'b1;
               end else if (s.cont && s.run) begin
                  n.cur_ch = s.ch_start;
                  n.start = 1'b1;
               end else begin
                  n.seq = SEQ_IDLE;
                  // Software start is one-shot; hardware sources stay armed
                  if (s.trig == TRIG_SOFT) n.run = 1'b0;
               end
            end
         end
      endcase

      // Routed to DMA the event raises no CPU interrupt
      n.irq = (|(n.factor & n.enable)) && !n.route;
      n.vec_out = s.vec_base + `VEC_OFFSET;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s <= '0;
         s.ready <= 1'b1;
         s.samp <= `RST_SAMPLE;
         s.div_sel <= `RST_DIV;
         s.prio <= `RST_PRIO;
         s.vec_base <= `RST_VEC_BASE;
         s.vec_out <= `RST_VEC_BASE + `VEC_OFFSET;
         s.trig <= TRIG_EXT;
         s.seq <= SEQ_IDLE;
      end else begin
         s <= n;
      end
   end

   assign HREADYOUT = s.ready;
   assign HRDATA = s.rdata;
   assign HRESP = s.resp;
   assign ANA_CH0_EN = s.ana_sel;
   assign ANA_CH_SEL = s.cur_ch;
   assign IRQ = s.irq;
   assign IRQ_LEVEL = s.prio;
   assign IRQ_VECTOR = s.vec_out;
   assign DMA_REQ = s.dma_req;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);

   chk_pin_analog_select: assert property (
      $rose(ANA_CH0_EN) |-> $past(s.wr_pend && s.addr == `OFF_PINSEL && HWDATA[0]))
      else $error("analog pin function set without a write");

   chk_soft_start: assert property (
      s.wr_pend && s.addr == `OFF_CTRL && HWDATA[1:0] == 2'b11
      && HWDATA[`LSB_TRIG +: 2] == 2'b11 && s.seq == SEQ_IDLE
      |-> ##2 s.start && s.cur_ch == s.ch_start)
      else $error("software run did not start the range");

   chk_range_step: assert property (
      s.seq == SEQ_BUSY && s.en && res.done && s.cur_ch != s.ch_end
      |=> s.start && s.cur_ch == $past(s.cur_ch) + 3'h1)
      else $error("channel range did not advance");

   chk_normal_once: assert property (
      s.seq == SEQ_BUSY && s.en && res.done && s.cur_ch == s.ch_end && !s.cont
      |=> s.seq == SEQ_IDLE && !s.start ##1 !s.start)
      else $error("normal mode did not stop at end of range");

   chk_complete_flag: assert property (
      s.seq == SEQ_BUSY && s.en && res.done |=> s.factor[0] && s.result == $past(res.value))
      else $error("completion did not set the factor flag");

   chk_factor_sticky: assert property (
      s.factor[0] && !(s.wr_pend && s.addr == `OFF_IRQ_STAT && HWDATA[0]) |=> s.factor[0])
      else $error("factor flag dropped without a clear");

   chk_irq_gated: assert property (
      IRQ |-> (|(s.factor & s.enable)) && !s.route)
      else $error("interrupt without enabled flag");

   chk_dma_route: assert property (
      DMA_REQ |-> $past(s.route) && s.factor[0])
      else $error("DMA request while routed to CPU");

   chk_overwrite_set: assert property (
      s.seq == SEQ_BUSY && s.en && res.done && s.unread && !data_read |=> s.overwrite_error_flag [*2])
      else $error("overwrite error not flagged");

   chk_vector_offset: assert property (
      $stable(s.vec_base) [*2] |-> IRQ_VECTOR == s.vec_base + `VEC_OFFSET)
      else $error("vector not at base plus offset");

   // Bus timing: writes take no wait state, reads exactly one
   chk_write_no_wait: assert property (
      HSEL && HREADY && HTRANS[1] && HWRITE |=> HREADYOUT)
      else $error("write phase stalled");

   chk_read_wait: assert property (
      HSEL && HREADY && HTRANS[1] && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait state not exactly one cycle");

   chk_read_clears: assert property (
      data_read && !res.done |=> !s.unread)
      else $error("data read left result marked unread");

   chk_presc_write: assert property (
      s.wr_pend && s.addr == `OFF_PRESC |=> s.div_sel == $past(HWDATA[2:0]))
      else $error("prescaler select not written");

   chk_range_write: assert property (
      s.wr_pend && s.addr == `OFF_RANGE
      |=> s.ch_start == $past(HWDATA[2:0]) && s.ch_end == $past(HWDATA[`LSB_CH_END +: 3]))
      else $error("channel range not written");

   chk_level_write: assert property (
      s.wr_pend && s.addr == `OFF_IRQ_PRIO |=> IRQ_LEVEL == $past(HWDATA[2:0]))
      else $error("priority level not written");

   // Sequencer hand-offs
   chk_trig_start: assert property (
      s.seq == SEQ_IDLE && s.en && s.run && trig_edge |=> s.start && s.seq == SEQ_BUSY)
      else $error("hardware edge did not start the range");

   chk_enable_abort: assert property (
      s.seq == SEQ_BUSY && !s.en |=> s.seq == SEQ_IDLE && !s.start)
      else $error("clearing enable did not abort");

   chk_run_oneshot: assert property (
      s.seq == SEQ_BUSY && s.en && res.done && s.cur_ch == s.ch_end && !s.cont
      && s.trig == TRIG_SOFT |=> !s.run)
      else $error("software run not cleared at end of range");

   // Hardware sources must stay armed for the next edge
   chk_hw_armed: assert property (
      s.seq == SEQ_BUSY && s.en && res.done && s.cur_ch == s.ch_end && !s.cont
      && s.trig != TRIG_SOFT && !s.wr_pend |=> $stable(s.run) && s.seq == SEQ_IDLE)
      else $error("hardware trigger disarmed after range");

   chk_dma_pulse: assert property (
      DMA_REQ |=> !DMA_REQ)
      else $error("DMA request longer than one cycle");

   chk_route_quiet: assert property (
      s.route && !(s.wr_pend && s.addr == `OFF_IRQ_ROUTE) |=> !IRQ)
      else $error("CPU interrupt while routed to DMA");
endmodule // adc_sequencer_control
`default_nettype wire

// ---- verif/analog_src.sv ----
`timescale 1ns/1ns
`default_nettype none
module analog_src
(
   input  wire logic [9:0] level,
   input  wire logic [9:0] dac,
   output logic            cmp
);
   // Ideal comparator; level is held steady for a whole range of conversions
   assign cmp = (level >= dac);
endmodule // analog_src
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "adc_consts.svh"
module tb_top;
   import adc_pkg::*;
   logic        clk, rst_n, hsel, hwrite, hready, hresp, pin, ext, t8, t16, cmp;
   logic        ch0_en, sample, irq, dma;
   logic [31:0] haddr, hwdata, hrdata, vec, vecout, rd;
   logic [1:0]  htrans;
   logic [2:0]  ch_sel, lvl;
   logic [9:0]  dac, vin;
   int          bad_count, n_tests, cyc, dma_cnt, samp_cyc, seed, i, n, r;

   adc_sequencer_control dut_u (
      .SYS_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .SHARED_PIN_IN(pin),
      .ANA_CH0_EN(ch0_en), .ANA_CH_SEL(ch_sel), .ANA_SAMPLE(sample), .ANA_DAC(dac),
      .ANA_CMP(cmp), .EXT_TRIG(ext), .TMR8_TRIG(t8), .TMR16_TRIG(t16), .IRQ(irq),
      .IRQ_LEVEL(lvl), .IRQ_VECTOR(vecout), .DMA_REQ(dma));

   analog_src src_u (.level(vin), .dac(dac), .cmp(cmp));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Monitors sample on the edge, before the design's updates land
   always @(posedge clk) begin
      cyc++;
      if (sample === 1'b1) samp_cyc++;
      if (dma === 1'b1) dma_cnt++;
      if (cyc == 80000) begin
         bad_count++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] f_data(input logic [2:0] ch, input logic [9:0] v);
      return {17'h0, ch, 2'b00, v};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Entered just after an edge; leaves at the edge that ends the data phase
   task automatic bus_go(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      bus_go(a, 1'b1, d);
   endtask

   task automatic bus_rd(input logic [7:0] a);
      bus_go(a, 1'b0, 32'h0);
   endtask

   task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
      int k;
      for (k = 0; k < 3000; k++) begin
         bus_rd(a);
         if (rd[b] === v) break;
      end
   endtask

   task automatic soft_conv;
      vin <= $random(seed);
      bus_wr(`OFF_CTRL, 32'h33);
      wait_bit(`OFF_IRQ_STAT, 0, 1'b1);
   endtask

   task automatic take_result(input logic [2:0] ch);
      bus_rd(`OFF_DATA);
      chk("data", f_data(ch, vin), rd);
      bus_wr(`OFF_IRQ_STAT, 32'h3);
   endtask

   task wrap_up;
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'he75f;
      {rst_n, hsel, hwrite, ext, t8, t16} = '0;
      {haddr, hwdata, htrans, vin} = '0;
      {bad_count, n_tests, cyc, dma_cnt, samp_cyc} = '0;
      pin = $random(seed);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("ch0_en", 32'h0, ch0_en);
      chk("vector", 32'h100, vecout);
      bus_rd(`OFF_PINSEL);
      chk("pinsel", {23'h0, pin, 8'h0}, rd);
      bus_rd(`OFF_PRESC);
      chk("presc", 32'h0, rd);
      bus_rd(`OFF_SAMPLE);
      chk("sample", 32'h9, rd);
      bus_rd(8'h3c);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, hresp);
      bus_wr(`OFF_PINSEL, 32'h1);
      @(posedge clk);
      chk("ch0_en", 32'h1, ch0_en);
      vec = $random(seed);
      bus_wr(`OFF_VEC_BASE, vec);
      bus_wr(`OFF_IRQ_PRIO, 32'h3);
      bus_wr(`OFF_IRQ_MASK, 32'h3);
      bus_wr(`OFF_CTRL, 32'h1);
      @(posedge clk);
      chk("level", 32'h3, lvl);
      chk("vector", vec + 32'h100, vecout);
      bus_rd(`OFF_CTRL);
      chk("ctrl_en", 32'h1, rd);
      // Every ratio; sampling kept well above half a conversion
      for (i = 0; i < 8; i++) begin
         n = 10 + ($random(seed) & 3);
         r = 1 << (i + 1);
         bus_wr(`OFF_PRESC, i);
         bus_wr(`OFF_SAMPLE, n);
         samp_cyc = 0;
         soft_conv();
         chk("irq", 32'h1, irq);
         chk("samp_len", 32'h1, samp_cyc > (n - 1) * r && samp_cyc <= n * r);
         bus_rd(`OFF_CTRL);
         chk("run_clr", 32'h31, rd);
         bus_rd(`OFF_DATA);
         chk("data", f_data(3'h0, vin), rd);
         bus_rd(`OFF_IRQ_STAT);
         chk("sticky", 32'h1, rd);
         bus_wr(`OFF_IRQ_STAT, 32'h1);
         @(posedge clk);
         @(posedge clk);
         chk("irq_clr", 32'h0, irq);
      end
      bus_wr(`OFF_PRESC, 32'h0);
      // Masked source stays quiet until enabled
      bus_wr(`OFF_IRQ_MASK, 32'h0);
      soft_conv();
      chk("irq_masked", 32'h0, irq);
      bus_wr(`OFF_IRQ_MASK, 32'h3);
      @(posedge clk);
      @(posedge clk);
      chk("irq_unmask", 32'h1, irq);
      take_result(3'h0);
      // Routed to DMA: one request, no CPU interrupt
      bus_wr(`OFF_IRQ_ROUTE, 32'h1);
      dma_cnt = 0;
      soft_conv();
      chk("irq_dma", 32'h0, irq);
      chk("dma_cnt", 32'h1, dma_cnt);
      bus_wr(`OFF_IRQ_ROUTE, 32'h0);
      take_result(3'h0);
      // Hardware trigger sources
      for (i = 0; i < 3; i++) begin
         vin <= $random(seed);
         bus_wr(`OFF_CTRL, 32'h3 | (i << 4));
         ext <= (i == 0);
         t8 <= (i == 1);
         t16 <= (i == 2);
         @(posedge clk);
         @(posedge clk);
         {ext, t8, t16} <= 3'b000;
         wait_bit(`OFF_IRQ_STAT, 0, 1'b1);
         chk("trig_done", 32'h1, rd[0]);
         take_result(3'h0);
      end
      // Two channels, neither read: overwrite
      bus_wr(`OFF_RANGE, 32'h21);
      vin <= $random(seed);
      bus_wr(`OFF_CTRL, 32'h33);
      wait_bit(`OFF_CTRL, 1, 1'b0);
      bus_rd(`OFF_CTRL);
      chk("owe_set", 32'h35, rd);
      bus_rd(`OFF_IRQ_STAT);
      chk("stat_owe", 32'h3, rd);
      bus_rd(`OFF_DATA);
      chk("range_last", f_data(3'h2, vin), rd);
      chk("ch_sel", 32'h2, ch_sel);
      bus_wr(`OFF_CTRL, 32'h31);
      bus_rd(`OFF_CTRL);
      chk("owe_clr", 32'h31, rd);
      bus_wr(`OFF_IRQ_STAT, 32'h3);
      // Continuous mode keeps running
      bus_wr(`OFF_RANGE, 32'h0);
      bus_wr(`OFF_CTRL, 32'h3b);
      wait_bit(`OFF_IRQ_STAT, 0, 1'b1);
      bus_wr(`OFF_IRQ_STAT, 32'h3);
      wait_bit(`OFF_IRQ_STAT, 0, 1'b1);
      bus_rd(`OFF_CTRL);
      chk("cont_run", 32'h1, rd[1]);
      bus_wr(`OFF_CTRL, 32'h1);
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
